// >>> tb/line_printer_check_logic_bench.sv
// Self-checking bench for the line printer check logic.
// Assumes lpck_top and lpck_printer_model are compiled before it.
`timescale 1ns/1ps
module line_printer_check_logic_bench;
    logic        clk_i, rst_i, cyc, stb, we, ack, bypass, limit, crst, start;
    logic        prn, supply, attn, pwr, ready, pchk, insync, hgate;
    logic [7:0]  adr, unit, print_position_counter, ev;
    logic [31:0] wdat, rdat, bq;
    logic [5:0]  fuse;
    logic [3:0]  sel;
    wire         done = ev[0], lstart = ev[1], drive = ev[2], due = ev[3];
    wire         last = ev[4], cmp = ev[5], sense = ev[6], drum = ev[7];
    int          error_cnt, samples_checked, hg_cnt, hg0;
    // Plane table: first event, second event, expected status bits 6..2
    logic [7:0]  e1 [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h7c};
    logic [7:0]  e2 [6] = '{8'h4c, 8'h20, 8'h20, 8'h4c, 8'h10, 8'h01};
    logic [31:0] ex [6] = '{32'h68, 32'h6c, 32'h7c, 32'h78, 32'h70, 32'h20};
    lpck_top lpck_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .printing_i(prn), .line_start_i(lstart), .driver_on_i(drive), .driver_due_i(due),
        .compare_i(cmp), .last_scan_i(last), .line_done_i(done),
        .current_sense_i(sense), .coil_protect_bypass_switch_i(bypass),
        .current_limit_switch_i(limit), .fuse_open_i(fuse), .drum_pulse_i(drum),
        .print_position_counter_i(print_position_counter), .check_reset_i(crst), .start_i(start),
        .coil_supply_o(supply), .attention_o(attn), .power_check_o(pwr),
        .print_ready_o(ready), .print_check_o(pchk), .in_sync_o(insync),
        .home_gate_o(hgate), .unit_addr_o(unit));
    lpck_printer_model lpck_printer_model_i (
        .clk_i(clk_i), .ev_o(ev), .printing_o(prn), .pcc_o(print_position_counter));
    // ****************************************************************
    // Clock, home gate counter and tasks
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Counts home gate pulses seen at the port
    always @(posedge clk_i) begin
        if (hgate === 1'b1) begin
            hg_cnt <= hg_cnt + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Classic single Wishbone cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        bq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) begin
            error_cnt++;
            $display("MISMATCH %0t bus timeout", $time);
            finish_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string s);
        bus(1'b0, a, 32'h0);
        chk(bq & m, e, s);
    endtask
    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask
    // Check reset, then operator start
    task automatic clr;
        @(posedge clk_i);
        crst <= 1'b1;
        @(posedge clk_i);
        crst <= 1'b0;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        settle();
    endtask
    // Run limit
    initial begin
        #2_000_000;
        error_cnt++;
        $display("MISMATCH %0t run timeout", $time);
        finish_test();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {cyc, stb, we, bypass, limit, crst, start} = 7'h00;
        adr = 8'h00;
        wdat = 32'h0;
        fuse = 6'h00;
        sel = 4'hf;
        error_cnt = 0;
        samples_checked = 0;
        hg_cnt = 0;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h08, 32'hff, 32'h0e, "unit reset");
        rd(8'h00, 32'h7ff, 32'h400, "status reset");
        bus(1'b1, 8'h08, 32'h5a);
        rd(8'h08, 32'hff, 32'h5a, "unit write");
        chk({24'h0, unit}, 32'h5a, "unit out");
        bus(1'b1, 8'h0c, 32'hc3a5_0f1e);
        rd(8'h0c, 32'hffff_ffff, 32'hc3a5_0f1e, "subchannel word");
        @(posedge clk_i);
        sel <= 4'h1;
        bus(1'b1, 8'h0c, 32'h0000_00ff);
        rd(8'h0c, 32'hffff_ffff, 32'hc3a5_0fff, "subchannel lane");
        @(posedge clk_i);
        sel <= 4'he;
        bus(1'b1, 8'h08, 32'h33);
        rd(8'h08, 32'hff, 32'h5a, "unit lane");
        @(posedge clk_i);
        sel <= 4'hf;
        bus(1'b1, 8'h10, 32'hffff_ffff);
        rd(8'h10, 32'hffff_ffff, 32'h0, "unmapped");
        bus(1'b1, 8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h7f, 32'h0, "status write");
        $display("test registers done");
        clr();
        lpck_printer_model_i.lvl(1'b1, 8'h01);
        for (int i = 0; i < 6; i++) begin
            lpck_printer_model_i.ev(e1[i]);
            lpck_printer_model_i.ev(e2[i]);
            rd(8'h00, 32'h7c, ex[i], "planes");
            clr();
        end
        rd(8'h00, 32'h7f, 32'h0, "cleared");
        $display("test planes done");
        lpck_printer_model_i.lvl(1'b0, 8'h01);
        lpck_printer_model_i.ev(8'h40);
        rd(8'h00, 32'h102, 32'h2, "idle current");
        chk({30'h0, supply, pchk}, 32'h1, "supply off");
        clr();
        rd(8'h00, 32'h102, 32'h100, "restart");
        lpck_printer_model_i.lvl(1'b1, 8'h01);
        lpck_printer_model_i.ev(8'h44);
        rd(8'h00, 32'h2, 32'h2, "driver not due");
        clr();
        lpck_printer_model_i.ev(8'h0c);
        rd(8'h00, 32'h2, 32'h2, "no sense");
        clr();
        @(posedge clk_i);
        bypass <= 1'b1;
        lpck_printer_model_i.ev(8'h44);
        rd(8'h00, 32'h2, 32'h0, "bypass");
        chk({31'h0, attn}, 32'h1, "attention");
        lpck_printer_model_i.ev(8'h40);
        rd(8'h00, 32'h2, 32'h2, "bypass sense");
        @(posedge clk_i);
        bypass <= 1'b0;
        clr();
        @(posedge clk_i);
        limit <= 1'b1;
        lpck_printer_model_i.ev(8'h40);
        rd(8'h00, 32'h2, 32'h2, "limit check");
        chk({31'h0, supply}, 32'h1, "limit supply");
        @(posedge clk_i);
        limit <= 1'b0;
        settle();
        chk({31'h0, supply}, 32'h0, "limit off");
        clr();
        $display("test coil done");
        @(posedge clk_i);
        fuse <= 6'h20;
        settle();
        chk({30'h0, pwr, ready}, 32'h3, "fuse open");
        @(posedge clk_i);
        fuse <= 6'h00;
        settle();
        chk({31'h0, pwr}, 32'h0, "fuse closed");
        $display("test fuse done");
        hg0 = hg_cnt;
        lpck_printer_model_i.lvl(1'b0, 8'h01);
        lpck_printer_model_i.ev(8'h80);
        rd(8'h00, 32'h401, 32'h400, "home in step");
        lpck_printer_model_i.lvl(1'b0, 8'h05);
        lpck_printer_model_i.ev(8'h80);
        rd(8'h00, 32'h1, 32'h1, "home out of step");
        clr();
        lpck_printer_model_i.lvl(1'b1, 8'h01);
        lpck_printer_model_i.ev(8'h02);
        rd(8'h00, 32'h200, 32'h200, "block set");
        lpck_printer_model_i.ev(8'h80);
        rd(8'h00, 32'h600, 32'h600, "block kept");
        lpck_printer_model_i.lvl(1'b0, 8'h01);
        lpck_printer_model_i.ev(8'h80);
        rd(8'h00, 32'h200, 32'h0, "block cleared");
        chk(32'(hg_cnt - hg0), 32'h4, "home gates");
        $display("test sync done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h08, 32'hff, 32'h0e, "unit after reset");
        rd(8'h00, 32'h7ff, 32'h400, "status after reset");
        $display("test reset done");
        finish_test();
    end
endmodule

// >>> tb/lpck_printer_model.sv
// Printer side model: hammer drivers, compare, current sense and drum.
// Assumes the bench calls ev and lvl; outputs change just after a rising edge.
`timescale 1ns/1ps
module lpck_printer_model (
    input  wire logic       clk_i,      // Attachment clock
    output logic      [7:0] ev_o,       // Drum, sense, cmp, last, due, drive, start, done
    output logic            printing_o, // Print line in progress
    output logic      [7:0] pcc_o       // Print position counter
);
    // Idle printer: no events, counter at its home value
    initial begin
        ev_o = 8'h00;
        printing_o = 1'b0;
        pcc_o = 8'h01;
    end
    // One-cycle burst of events; bit 7 is the extra drum pulse per turn
    task automatic ev(input logic [7:0] v);
        @(posedge clk_i);
        ev_o <= v;
        @(posedge clk_i);
        ev_o <= 8'h00;
    endtask
    // Print level and counter value
    task automatic lvl(input logic p, input logic [7:0] c);
        @(posedge clk_i);
        printing_o <= p;
        pcc_o <= c;
    endtask
endmodule

// >>> verilog/lpck_defines.svh
// Constants for the line printer check logic.
// Assumes inclusion by the design module.
`ifndef LPCK_DEFINES_SVH
`define LPCK_DEFINES_SVH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define LPCK_ADR_STATUS  8'h00
`define LPCK_ADR_CONTROL 8'h04
`define LPCK_ADR_UNIT    8'h08
`define LPCK_ADR_SUBCW   8'h0c
// ****************************************************************
// Values
// ****************************************************************
`define LPCK_UNIT_RST    8'h0e
`define LPCK_PCC_HOME    8'h01
`define LPCK_PLANE_NOCMP 3'h2
`define LPCK_PLANE_NOFIR 3'h3
`define LPCK_PLANE_CMPLC 3'h7
`define LPCK_PLANE_FIRLC 3'h6
`define LPCK_PLANE_LAST  3'h4
`endif

// >>> verilog/lpck_pkg.sv
// Types for the line printer check logic.
// Assumes the defines header is compiled with it.
package lpck_pkg;
    // Check indications toward software
    typedef struct packed {
        logic       hammer_check;
        logic       line_complete_plane;
        logic [2:0] planes;
        logic       coil_protect;
        logic       sync_check;
    } lpck_checks_type;
    // Whole module state
    typedef struct packed {
        lpck_checks_type chk;
        logic            ready;
        logic            in_sync;
        logic            block_reset;
        logic            drum_d;
        logic [7:0]      unit_addr;
        logic [31:0]     subchannel_control_word;
        logic            ack;
        logic [31:0]     dat;
    } lpck_state_type;
endpackage

// >>> verilog/lpck_top.sv
// Line printer check logic: hammer, coil-protect, fuse and sync checks.
// Assumes a classic Wishbone master and printer signals synchronous to clk_i.
`timescale 1ns/1ps
`include "lpck_defines.svh"
module lpck_top
    import lpck_pkg::*;
(
    input  wire logic        clk_i,          // 40 MHz clock
    input  wire logic        rst_i,          // Synchronous reset
    input  wire logic        wb_cyc_i,       // Bus cycle
    input  wire logic        wb_stb_i,       // Bus strobe
    input  wire logic        wb_we_i,        // Write enable
    input  wire logic [7:0]  wb_adr_i,       // Byte address
    input  wire logic [3:0]  wb_sel_i,       // Byte lanes
    input  wire logic [31:0] wb_dat_i,       // Write data
    output logic      [31:0] wb_dat_o,       // Read data
    output logic             wb_ack_o,       // Acknowledge
    input  wire logic        printing_i,     // Print line in progress
    input  wire logic        line_start_i,   // Print line starts (pulse)
    input  wire logic        driver_on_i,    // Any hammer driver on
    input  wire logic        driver_due_i,   // A driver should be on now
    input  wire logic        compare_i,      // Compare pulse
    input  wire logic        last_scan_i,    // Last scan of line (pulse)
    input  wire logic        line_done_i,    // Line complete pulse
    input  wire logic        current_sense_i,// Coil current sensed
    input  wire logic        coil_protect_bypass_switch_i,
    input  wire logic        current_limit_switch_i,
    input  wire logic [5:0]  fuse_open_i,    // One per monitored fuse
    input  wire logic        drum_pulse_i,   // Extra drum pulse per turn
    input  wire logic [7:0]  print_position_counter_i,
    input  wire logic        check_reset_i,  // Operator check reset
    input  wire logic        start_i,        // Operator start
    output logic             coil_supply_o,  // Hammer coil supply on
    output logic             attention_o,    // Console attention light
    output logic             power_check_o,  // Power check light
    output logic             print_ready_o,  // Printer ready
    output logic             print_check_o,  // Print check light
    output logic             in_sync_o,      // Printer in sync
    output logic             home_gate_o,    // Home gate pulse
    output logic [7:0]       unit_addr_o     // Assigned unit address
);
    // ****************************************************************
    // State
    // ****************************************************************
    lpck_state_type st_r;      // Registered state
    lpck_state_type st_nxt;    // Next state
    logic           home;      // Home gate this cycle
    logic           hcheck;    // Hammer check event
    logic [2:0]     code;      // Plane code of event
    logic           cp_hammer; // Coil check from hammer check
    logic           cp_sense;  // Coil check from current sense
    logic           wr;        // Bus write strobe
    logic           rd;        // Bus read strobe

    // Byte-lane merge for writes
    function automatic logic [31:0] lane(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // Event decode
    // ****************************************************************
    always_comb begin
        home = drum_pulse_i & ~st_r.drum_d;
        hcheck = 1'b1;
        code = 3'h0;
        if (compare_i & st_r.chk.line_complete_plane) begin
            code = `LPCK_PLANE_CMPLC;
        end else if (driver_on_i & st_r.chk.line_complete_plane) begin
            code = `LPCK_PLANE_FIRLC;
        end else if (compare_i & ~driver_on_i) begin
            code = `LPCK_PLANE_NOFIR;
        end else if (driver_on_i & ~compare_i) begin
            code = `LPCK_PLANE_NOCMP;
        end else if (last_scan_i & ~compare_i) begin
            code = `LPCK_PLANE_LAST;
        end else begin
            hcheck = 1'b0;
        end
        // Driver on when not due while printing
        cp_hammer = printing_i & driver_on_i & ~driver_due_i
                    & ~coil_protect_bypass_switch_i;
        // Idle current, or no current with driver on
        cp_sense = (current_sense_i & ~driver_due_i & ~driver_on_i)
                 | (printing_i & driver_on_i & ~current_sense_i);
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack;
        rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.drum_d = drum_pulse_i;
        // Check latches: set wins over reset
        if (check_reset_i) begin
            st_nxt.chk = '0;
        end
        if (line_done_i) begin
            st_nxt.chk.line_complete_plane = 1'b1;
        end
        if (hcheck) begin
            st_nxt.chk.hammer_check = 1'b1;
            st_nxt.chk.line_complete_plane = 1'b1;
            st_nxt.chk.planes = st_nxt.chk.planes | code;
        end
        if (cp_hammer | cp_sense) begin
            st_nxt.chk.coil_protect = 1'b1;
            st_nxt.ready = 1'b0;
        end else if (start_i & ~st_r.chk.coil_protect & ~check_reset_i) begin
            st_nxt.ready = 1'b1;
        end
        // Block-reset: set on line start, cleared on idle home
        if (line_start_i) begin
            st_nxt.block_reset = 1'b1;
        end else if (home & ~printing_i) begin
            st_nxt.block_reset = 1'b0;
        end
        // Sync check and resync at home
        if (home) begin
            if (print_position_counter_i != `LPCK_PCC_HOME) begin
                st_nxt.chk.sync_check = 1'b1;
            end
            if (~st_r.block_reset) begin
                st_nxt.in_sync = 1'b1;
            end else begin
                st_nxt.in_sync = st_r.in_sync
                               & (print_position_counter_i == `LPCK_PCC_HOME);
            end
        end else if (drum_pulse_i & ~st_r.block_reset) begin
            st_nxt.in_sync = 1'b0;
        end
        // Bus slave
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        st_nxt.dat = '0;
        if (wr) begin
            case (wb_adr_i)
                `LPCK_ADR_UNIT: begin
                    if (wb_sel_i[0]) begin
                        st_nxt.unit_addr = wb_dat_i[7:0];
                    end
                end
                `LPCK_ADR_SUBCW: begin
                    st_nxt.subchannel_control_word =
                        lane(st_r.subchannel_control_word, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (wb_adr_i)
                `LPCK_ADR_STATUS:  st_nxt.dat = {21'h00000, st_r.in_sync,
                                                 st_r.block_reset, st_r.ready,
                                                 |fuse_open_i, st_r.chk};
                `LPCK_ADR_CONTROL: st_nxt.dat = {29'h00000000,
                                                 coil_protect_bypass_switch_i,
                                                 current_limit_switch_i, printing_i};
                `LPCK_ADR_UNIT:    st_nxt.dat = {24'h000000, st_r.unit_addr};
                `LPCK_ADR_SUBCW:   st_nxt.dat = st_r.subchannel_control_word;
                default:           st_nxt.dat = '0;
            endcase
        end
        if (rst_i) begin
            st_nxt = '0;
            st_nxt.unit_addr = `LPCK_UNIT_RST;
            st_nxt.in_sync = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign wb_ack_o      = st_r.ack;
    assign wb_dat_o      = st_r.dat;
    assign coil_supply_o = ~st_r.chk.coil_protect | current_limit_switch_i;
    assign attention_o   = coil_protect_bypass_switch_i;
    assign power_check_o = |fuse_open_i;
    assign print_ready_o = st_r.ready & ~st_r.chk.coil_protect;
    assign print_check_o = st_r.chk.coil_protect;
    assign in_sync_o     = st_r.in_sync;
    assign home_gate_o   = home;
    assign unit_addr_o   = st_r.unit_addr;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_hcheck;
        @(posedge clk_i) disable iff (rst_i) hcheck |=> st_r.chk.hammer_check;
    endproperty
    a_hcheck: assert property (p_hcheck) else $error("hammer check not set");
    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
            st_r.chk.coil_protect & ~check_reset_i |=> st_r.chk.coil_protect;
    endproperty
    a_hold: assert property (p_hold) else $error("coil check lost");
    property p_supply;
        @(posedge clk_i) disable iff (rst_i)
            st_r.chk.coil_protect & ~current_limit_switch_i |-> ~coil_supply_o;
    endproperty
    a_supply: assert property (p_supply) else $error("supply stayed on");
    property p_limit;
        @(posedge clk_i) disable iff (rst_i) current_limit_switch_i |-> coil_supply_o;
    endproperty
    a_limit: assert property (p_limit) else $error("supply dropped");
    property p_idle;
        @(posedge clk_i) disable iff (rst_i)
            current_sense_i & ~driver_on_i & ~driver_due_i |=> print_check_o;
    endproperty
    a_idle: assert property (p_idle) else $error("idle current missed");
    property p_sync;
        @(posedge clk_i) disable iff (rst_i)
            home & (print_position_counter_i != `LPCK_PCC_HOME) |=> st_r.chk.sync_check;
    endproperty
    a_sync: assert property (p_sync) else $error("sync check missed");
    property p_ready;
        @(posedge clk_i) disable iff (rst_i) print_check_o |-> ~print_ready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("ready with check");
    property p_blk;
        @(posedge clk_i) disable iff (rst_i) line_start_i |=> st_r.block_reset;
    endproperty
    a_blk: assert property (p_blk) else $error("block reset not set");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> ~wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held");

    // ****************************************************************
    // Plane code, coil check and fuse assertions
    // ****************************************************************
    // Driver fired with no compare: plane two
    property p_nocmp;
        @(posedge clk_i) disable iff (rst_i)
            driver_on_i & ~compare_i & ~st_r.chk.line_complete_plane |=> st_r.chk.planes[1];
    endproperty
    a_nocmp: assert property (p_nocmp) else $error("plane two missing");
    // Compare with no driver: planes one and two
    property p_nofir;
        @(posedge clk_i) disable iff (rst_i)
            compare_i & ~driver_on_i & ~st_r.chk.line_complete_plane |=> &st_r.chk.planes[1:0];
    endproperty
    a_nofir: assert property (p_nofir) else $error("planes one two missing");
    // Compare after line complete: all three planes
    property p_cmplc;
        @(posedge clk_i) disable iff (rst_i)
            compare_i & st_r.chk.line_complete_plane |=> &st_r.chk.planes;
    endproperty
    a_cmplc: assert property (p_cmplc) else $error("all planes missing");
    // Driver after line complete: planes two and three
    property p_firlc;
        @(posedge clk_i) disable iff (rst_i)
            driver_on_i & ~compare_i & st_r.chk.line_complete_plane |=> &st_r.chk.planes[2:1];
    endproperty
    a_firlc: assert property (p_firlc) else $error("planes two three missing");
    // Last scan with no compare: plane three
    property p_last;
        @(posedge clk_i) disable iff (rst_i)
            last_scan_i & ~compare_i & ~driver_on_i & ~st_r.chk.line_complete_plane
            |=> st_r.chk.planes[2];
    endproperty
    a_last: assert property (p_last) else $error("plane three missing");
    // Line done marks the line-complete plane
    property p_done;
        @(posedge clk_i) disable iff (rst_i) line_done_i |=> st_r.chk.line_complete_plane;
    endproperty
    a_done: assert property (p_done) else $error("line complete missing");
    // Driver on while not due during printing trips the coil check
    property p_hammer_cp;
        @(posedge clk_i) disable iff (rst_i)
            printing_i & driver_on_i & ~driver_due_i & ~coil_protect_bypass_switch_i
            |=> print_check_o;
    endproperty
    a_hammer_cp: assert property (p_hammer_cp) else $error("hammer coil check missed");
    // Driver on with no coil current trips the coil check
    property p_sense_cp;
        @(posedge clk_i) disable iff (rst_i)
            printing_i & driver_on_i & ~current_sense_i |=> print_check_o;
    endproperty
    a_sense_cp: assert property (p_sense_cp) else $error("sense coil check missed");
    // Bypass keeps a hammer check from reaching the coil latch
    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
            coil_protect_bypass_switch_i & ~st_r.chk.coil_protect
            & ~(current_sense_i & ~driver_due_i & ~driver_on_i)
            & ~(printing_i & driver_on_i & ~current_sense_i) |=> ~st_r.chk.coil_protect;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass ignored");
    // Attention light follows the bypass switch
    property p_attn;
        @(posedge clk_i) disable iff (rst_i)
            attention_o == coil_protect_bypass_switch_i;
    endproperty
    a_attn: assert property (p_attn) else $error("attention wrong");
    // Power check light follows the fuses
    property p_fuse;
        @(posedge clk_i) disable iff (rst_i)
            power_check_o == (|fuse_open_i);
    endproperty
    a_fuse: assert property (p_fuse) else $error("power check wrong");
    // A new coil check leaves the printer not ready
    property p_notready;
        @(posedge clk_i) disable iff (rst_i)
            $rose(st_r.chk.coil_protect) |-> ~st_r.ready;
    endproperty
    a_notready: assert property (p_notready) else $error("ready after coil check");

    // ****************************************************************
    // Sync assertions
    // ****************************************************************
    // Home with block-reset off resyncs the printer
    property p_resync;
        @(posedge clk_i) disable iff (rst_i)
            home & ~st_r.block_reset |=> in_sync_o;
    endproperty
    a_resync: assert property (p_resync) else $error("resync missed");
    // Drum held high after its edge drops in-sync unless blocked
    property p_desync;
        @(posedge clk_i) disable iff (rst_i)
            drum_pulse_i & ~home & ~st_r.block_reset |=> ~in_sync_o;
    endproperty
    a_desync: assert property (p_desync) else $error("in-sync not reset");
    // Idle home gate clears block-reset
    property p_blkclr;
        @(posedge clk_i) disable iff (rst_i)
            home & ~printing_i & ~line_start_i |=> ~st_r.block_reset;
    endproperty
    a_blkclr: assert property (p_blkclr) else $error("block reset kept");
    // Home gate is a single-cycle pulse per drum edge
    property p_home;
        @(posedge clk_i) disable iff (rst_i)
            home_gate_o |=> ~home_gate_o;
    endproperty
    a_home: assert property (p_home) else $error("home gate too long");

    // Main scenarios
    c_sync: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st_r.chk.sync_check));
    c_coil: cover property (@(posedge clk_i) disable iff (rst_i) $rose(print_check_o));
    c_home: cover property (@(posedge clk_i) disable iff (rst_i) home);
    c_ham:  cover property (@(posedge clk_i) disable iff (rst_i) hcheck);
endmodule
